// ---- pin_function_mux.sv ----
// One pin's selection between its general-purpose driver and its peripherals.
`timescale 1ns/10ps
`default_nettype none
module pin_function_mux (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Selection
   input wire logic periph_mode,
   input wire logic [2:0] sel,
   input wire logic sel_valid,
   // Sources
   input wire pin_select_pkg::pin_drive_s gpio_drive,
   input wire logic [pin_select_pkg::slot_count-1:0] func_out,
   input wire logic [pin_select_pkg::slot_count-1:0] func_oe,
   input wire logic pad_in,
   // Registered results
   output pin_select_pkg::pin_drive_s pad_drive,
   output logic [pin_select_pkg::slot_count-1:0] func_in
);

   // ----------------------------------------------------------------
   // Selection
   // ----------------------------------------------------------------
   // A reserved code leaves the pin with its general-purpose driver, so a
   // bad write can never hand the pad to an unrelated peripheral.
   wire logic use_periph = periph_mode & sel_valid;
   wire logic [pin_select_pkg::slot_count-1:0] slot_hit =
      use_periph ? (pin_select_pkg::slot_count'(1) << sel) : '0;
   pin_select_pkg::pin_drive_s next_pad_drive;
   assign next_pad_drive.out = use_periph ? func_out[sel] : gpio_drive.out;
   assign next_pad_drive.oe = use_periph ? func_oe[sel] : gpio_drive.oe;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_drive <= '0;
         func_in <= '0;
      end else begin
         pad_drive <= next_pad_drive;
         func_in <= slot_hit & {pin_select_pkg::slot_count{pad_in}};
      end
   end

endmodule
`default_nettype wire

// ---- pin_select_assertions.sv ----
// Concurrent checks of the port alternate function selector.
`timescale 1ns/10ps
`default_nettype none
module pin_select_assertions (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Pins
   input wire logic [7:0] gpio_out,
   input wire logic [7:0][4:0] func_out,
   input wire logic [7:0][4:0] func_in,
   input wire logic [7:0] pad_out
);
   // Shadows let a pin be judged only once its selection has been steady for two edges.
   logic [7:0] mode_q, mode_p, gpo_q, wr_a;
   logic [15:0] pa_q, pa_p;
   logic [7:0][4:0] fo_q;
   logic [1:0] up;
   logic wr_ph;
   wire logic calm = up == 2'h3 && mode_q == mode_p && pa_q == pa_p;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {mode_q, mode_p, gpo_q, wr_a, pa_q, pa_p, fo_q, up, wr_ph} <= '0;
      end else begin
         wr_ph <= hsel && hready && htrans == 2'h2 && hwrite;
         wr_a <= haddr[7:0];
         if (wr_ph && wr_a == 8'h1c) begin
            mode_q <= hwdata[7:0];
         end
         if (wr_ph && wr_a == 8'h14) begin
            pa_q <= hwdata[15:0] & 16'h3f7f;
         end
         mode_p <= mode_q;
         pa_p <= pa_q;
         gpo_q <= gpio_out;
         fo_q <= func_out;
         up <= (up == 2'h3) ? up : up + 2'h1;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_phase(logic [31:0] a);
      hsel && hready && htrans == 2'h2 && !hwrite && haddr == a;
   endsequence
   a_ready_always: assert property (hreadyout) else $error("hreadyout low");
   a_resp_okay: assert property (!hresp) else $error("hresp not okay");
   a_rdata_idle: assert property (!(hsel && hready && htrans == 2'h2 && !hwrite)
      |=> hrdata == 32'h0) else $error("hrdata not zero outside a read");
   a_porta_rmask: assert property (rd_phase(32'h14) |=> (hrdata & 32'hffffc080) == 32'h0)
      else $error("port a reserved bits read nonzero");
   a_portb_rmask: assert property (rd_phase(32'h18) |=> (hrdata & 32'hffffe00f) == 32'h0)
      else $error("port b reserved bits read nonzero");
   a_mode_readback: assert property (rd_phase(32'h1c) |=> hrdata == {24'h0, mode_q})
      else $error("mode register read back wrong");
   a_gpio_passthru: assert property (calm && mode_q == 8'h00 |-> pad_out == gpo_q)
      else $error("pad not driven by gpio");
   a_func_quiet: assert property (calm && mode_q == 8'h00 |-> func_in == '0)
      else $error("peripheral input seen in gpio mode");
   a_pa11_route: assert property (calm && mode_q[0] |-> pad_out[0] == fo_q[0][pa_q[6]])
      else $error("pin a11 routed wrong");
   a_pa14_route: assert property (calm && mode_q[3] |-> pad_out[3] ==
      (pa_q[13:12] == 2'h3 ? gpo_q[3] : fo_q[3][pa_q[13:12]])) else $error("pin a14 routed wrong");
endmodule
bind port_alternate_function_select pin_select_assertions u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .gpio_out(gpio_out), .func_out(func_out),
   .func_in(func_in), .pad_out(pad_out)
);
`default_nettype wire

// ---- pin_select_pkg.sv ----
// Shared constants and types of the port alternate function selector.
package pin_select_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] porta_sel_addr = 8'h14;
   localparam logic [7:0] portb_sel_addr = 8'h18;
   localparam logic [7:0] periph_mode_addr = 8'h1c;
   localparam logic [7:0] pin_level_addr = 8'h20;

   localparam logic [15:0] porta_sel_reset = 16'h0000;
   localparam logic [15:0] portb_sel_reset = 16'h0000;
   localparam logic [7:0] periph_mode_reset = 8'h00;

   // Writable bits; reserved bits are held at zero.
   localparam logic [15:0] porta_sel_mask = 16'h3f7f;
   localparam logic [15:0] portb_sel_mask = 16'h1ff0;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int pa14_lsb = 12;
   localparam int pa13_lsb = 10;
   localparam int pa12_lsb = 8;
   localparam int pa11_lsb = 6;
   localparam int pb5_lsb = 11;
   localparam int pb4_lsb = 8;
   localparam int pb3_lsb = 6;
   localparam int pb2_lsb = 4;

   // ----------------------------------------------------------------
   // Pins and function slots
   // ----------------------------------------------------------------
   localparam int pin_count = 8;
   localparam int slot_count = 5;
   localparam int pin_pa11 = 0;
   localparam int pin_pa12 = 1;
   localparam int pin_pa13 = 2;
   localparam int pin_pa14 = 3;
   localparam int pin_pb2 = 4;
   localparam int pin_pb3 = 5;
   localparam int pin_pb4 = 6;
   localparam int pin_pb5 = 7;

   // Slot numbers equal the selector code of each pin.
   localparam logic [2:0] pa14_timer_b_ch3 = 3'h0;
   localparam logic [2:0] pa14_spi_b_master_out = 3'h1;
   localparam logic [2:0] pa14_timer_a_ch3 = 3'h2;
   localparam logic [2:0] pa13_timer_b_ch2 = 3'h0;
   localparam logic [2:0] pa13_spi_b_master_in = 3'h1;
   localparam logic [2:0] pa13_timer_a_ch2 = 3'h2;
   localparam logic [2:0] pa12_timer_b_ch1 = 3'h0;
   localparam logic [2:0] pa12_spi_b_serial_clock = 3'h1;
   localparam logic [2:0] pa12_timer_a_ch1 = 3'h2;
   localparam logic [2:0] pa11_comparator_b_input_2 = 3'h0;
   localparam logic [2:0] pa11_timer_b_ch3 = 3'h1;
   localparam logic [2:0] pb5_timer_a_ch1 = 3'h0;
   localparam logic [2:0] pb5_pwm_fault_input_3 = 3'h1;
   localparam logic [2:0] pb5_external_clock_input = 3'h2;
   localparam logic [2:0] pb4_timer_a_ch0 = 3'h0;
   localparam logic [2:0] pb4_clock_output = 3'h1;
   localparam logic [2:0] pb4_spi_b_slave_select = 3'h2;
   localparam logic [2:0] pb4_timer_b_ch0 = 3'h3;
   localparam logic [2:0] pb4_pwm_pair45_ext_source = 3'h4;
   localparam logic [2:0] pb3_spi_a_master_out = 3'h0;
   localparam logic [2:0] pb3_timer_a_ch3 = 3'h1;
   localparam logic [2:0] pb3_pwm_pair23_ext_source = 3'h2;
   localparam logic [2:0] pb2_spi_a_master_in = 3'h0;
   localparam logic [2:0] pb2_timer_a_ch2 = 3'h1;
   localparam logic [2:0] pb2_pwm_pair01_ext_source = 3'h2;

   // Highest legal code for a two-bit selector, the one-bit one and the three-bit one.
   localparam logic [2:0] two_bit_max_code = 3'h2;
   localparam logic [2:0] one_bit_max_code = 3'h1;
   localparam logic [2:0] pb4_max_code = 3'h4;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_s;

   localparam logic [1:0] htrans_nonseq = 2'h2;

endpackage

// ---- port_alternate_function_select.sv ----
// Port alternate function selector with its AHB-Lite register slave.
// How it works
// - Port A pin 14 code 0 timer B ch3, 1 SPI B out, 2 timer A ch3.
// - Port A pin 13 code 0 timer B ch2, 1 SPI B in, 2 timer A ch2.
// - Port A pin 12 code 0 timer B ch1, 1 SPI B clock, 2 timer A ch1.
// - Port A pin 11 bit 6: 0 comparator B input 2, 1 timer B ch3.
// - Port B pin 5 code 0 timer A ch1, 1 fault 3, 2 clock in.
// - Port B pin 4 codes 0 to 4 pick timer, clock out, slave select, PWM.
// - Port B pin 3 code 0 SPI A out, 1 timer A ch3, 2 PWM 2/3 source.
// - Port B pin 2 code 0 SPI A in, 1 timer A ch2, 2 PWM 0/1 source.
// - Pins reset to general-purpose; selections act only in peripheral mode.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module port_alternate_function_select (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // General-purpose port drivers, one per covered pin
   input wire logic [pin_select_pkg::pin_count-1:0] gpio_out,
   input wire logic [pin_select_pkg::pin_count-1:0] gpio_oe,
   // Peripheral drivers and receivers, indexed by pin then selector code
   input wire logic [pin_select_pkg::pin_count-1:0][pin_select_pkg::slot_count-1:0] func_out,
   input wire logic [pin_select_pkg::pin_count-1:0][pin_select_pkg::slot_count-1:0] func_oe,
   output logic [pin_select_pkg::pin_count-1:0][pin_select_pkg::slot_count-1:0] func_in,
   // Pads
   input wire logic [pin_select_pkg::pin_count-1:0] pad_in,
   output logic [pin_select_pkg::pin_count-1:0] pad_out,
   output logic [pin_select_pkg::pin_count-1:0] pad_oe
);

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic logic code_ok(input logic [2:0] code, input logic [2:0] max_code);
      code_ok = (code <= max_code);
   endfunction

   function automatic logic addr_is(input logic [31:0] addr, input logic [7:0] reg_addr);
      addr_is = (addr[31:8] == 24'h000000) && (addr[7:0] == reg_addr);
   endfunction

   // ----------------------------------------------------------------
   // Bus address phase
   // ----------------------------------------------------------------
   logic [15:0] porta_sel;
   logic [15:0] portb_sel;
   logic [7:0] periph_mode;
   logic [7:0] pin_level;
   logic wr_pending;
   logic [31:0] wr_addr;

   wire logic take = hsel & hready & (htrans == pin_select_pkg::htrans_nonseq);
   wire logic take_write = take & hwrite;
   wire logic take_read = take & ~hwrite;

   // Data phase of a write lands here; a read in the same cycle sees it.
   wire logic wr_porta = wr_pending & addr_is(wr_addr, pin_select_pkg::porta_sel_addr);
   wire logic wr_portb = wr_pending & addr_is(wr_addr, pin_select_pkg::portb_sel_addr);
   wire logic wr_mode = wr_pending & addr_is(wr_addr, pin_select_pkg::periph_mode_addr);

   // Reserved positions are masked so they store nothing and read zero.
   wire logic [15:0] next_porta_sel = wr_porta ?
      (hwdata[15:0] & pin_select_pkg::porta_sel_mask) : porta_sel;
   wire logic [15:0] next_portb_sel = wr_portb ?
      (hwdata[15:0] & pin_select_pkg::portb_sel_mask) : portb_sel;
   wire logic [7:0] next_periph_mode = wr_mode ? hwdata[7:0] : periph_mode;

   wire logic [31:0] read_value =
      addr_is(haddr, pin_select_pkg::porta_sel_addr) ? {16'h0000, next_porta_sel} :
      addr_is(haddr, pin_select_pkg::portb_sel_addr) ? {16'h0000, next_portb_sel} :
      addr_is(haddr, pin_select_pkg::periph_mode_addr) ? {24'h000000, next_periph_mode} :
      addr_is(haddr, pin_select_pkg::pin_level_addr) ? {24'h000000, pin_level} :
      32'h00000000;

   // ----------------------------------------------------------------
   // Bus and register state
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         porta_sel <= pin_select_pkg::porta_sel_reset;
         portb_sel <= pin_select_pkg::portb_sel_reset;
         periph_mode <= pin_select_pkg::periph_mode_reset;
         pin_level <= 8'h00;
         wr_pending <= 1'b0;
         wr_addr <= 32'h00000000;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         porta_sel <= next_porta_sel;
         portb_sel <= next_portb_sel;
         periph_mode <= next_periph_mode;
         pin_level <= pad_in;
         wr_pending <= take_write;
         wr_addr <= take_write ? haddr : wr_addr;
         hrdata <= take_read ? read_value : 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Field extraction
   // ----------------------------------------------------------------
   // Bits 15-14 and 7 of port A and bit 3 of port B are never looked at,
   // so a careless write there changes no pin.
   logic [pin_select_pkg::pin_count-1:0][2:0] sel;
   logic [pin_select_pkg::pin_count-1:0] sel_valid;

   assign sel[pin_select_pkg::pin_pa14] =
      {1'b0, porta_sel[pin_select_pkg::pa14_lsb +: 2]};
   assign sel[pin_select_pkg::pin_pa13] =
      {1'b0, porta_sel[pin_select_pkg::pa13_lsb +: 2]};
   assign sel[pin_select_pkg::pin_pa12] =
      {1'b0, porta_sel[pin_select_pkg::pa12_lsb +: 2]};
   assign sel[pin_select_pkg::pin_pa11] =
      {2'b00, porta_sel[pin_select_pkg::pa11_lsb]};
   assign sel[pin_select_pkg::pin_pb5] =
      {1'b0, portb_sel[pin_select_pkg::pb5_lsb +: 2]};
   assign sel[pin_select_pkg::pin_pb4] =
      portb_sel[pin_select_pkg::pb4_lsb +: 3];
   assign sel[pin_select_pkg::pin_pb3] =
      {1'b0, portb_sel[pin_select_pkg::pb3_lsb +: 2]};
   assign sel[pin_select_pkg::pin_pb2] =
      {1'b0, portb_sel[pin_select_pkg::pb2_lsb +: 2]};

   // Code 11 of a two-bit field and codes above 100 of port B pin 4 are
   // treated as reserved and leave the pin on its general-purpose driver.
   assign sel_valid[pin_select_pkg::pin_pa14] =
      code_ok(sel[pin_select_pkg::pin_pa14], pin_select_pkg::two_bit_max_code);
   assign sel_valid[pin_select_pkg::pin_pa13] =
      code_ok(sel[pin_select_pkg::pin_pa13], pin_select_pkg::two_bit_max_code);
   assign sel_valid[pin_select_pkg::pin_pa12] =
      code_ok(sel[pin_select_pkg::pin_pa12], pin_select_pkg::two_bit_max_code);
   assign sel_valid[pin_select_pkg::pin_pa11] =
      code_ok(sel[pin_select_pkg::pin_pa11], pin_select_pkg::one_bit_max_code);
   assign sel_valid[pin_select_pkg::pin_pb5] =
      code_ok(sel[pin_select_pkg::pin_pb5], pin_select_pkg::two_bit_max_code);
   assign sel_valid[pin_select_pkg::pin_pb4] =
      code_ok(sel[pin_select_pkg::pin_pb4], pin_select_pkg::pb4_max_code);
   assign sel_valid[pin_select_pkg::pin_pb3] =
      code_ok(sel[pin_select_pkg::pin_pb3], pin_select_pkg::two_bit_max_code);
   assign sel_valid[pin_select_pkg::pin_pb2] =
      code_ok(sel[pin_select_pkg::pin_pb2], pin_select_pkg::two_bit_max_code);

   // ----------------------------------------------------------------
   // Pin multiplexers
   // ----------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < pin_select_pkg::pin_count; p++) begin : g_pin
         pin_select_pkg::pin_drive_s gpio_drive;
         pin_select_pkg::pin_drive_s pad_drive;
         assign gpio_drive.out = gpio_out[p];
         assign gpio_drive.oe = gpio_oe[p];
         // Peripheral mode off keeps the general-purpose driver on the pad.
         pin_function_mux u_mux (
            .clk(hclk),
            .rst_n(hresetn),
            .periph_mode(periph_mode[p]),
            .sel(sel[p]),
            .sel_valid(sel_valid[p]),
            .gpio_drive(gpio_drive),
            .func_out(func_out[p]),
            .func_oe(func_oe[p]),
            .pad_in(pad_in[p]),
            .pad_drive(pad_drive),
            .func_in(func_in[p])
         );
         assign pad_out[p] = pad_drive.out;
         assign pad_oe[p] = pad_drive.oe;
      end
   endgenerate

endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench of the port alternate function selector.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, r, seed = 32'h1e86;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0, hreadyout, hresp;
   wire logic hready;
   logic [7:0] gpio_out = 8'h0, gpio_oe = 8'h0, pad_in = 8'h0, pad_out, pad_oe, md;
   logic [7:0][4:0] func_out = '0, func_oe = '0, func_in;
   logic [15:0] pa, pb;
   logic [63:0] w;
   int fail_count = 0;
   int n_checks = 0;
   assign hready = hreadyout;
   always #25 hclk = ~hclk;
   port_alternate_function_select DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .func_out(func_out), .func_oe(func_oe), .func_in(func_in), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe)
   );
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [2:0] code_of(int p);
      case (p)
         0: return {2'h0, pa[6]};
         1: return {1'b0, pa[9:8]};
         2: return {1'b0, pa[11:10]};
         3: return {1'b0, pa[13:12]};
         4: return {1'b0, pb[5:4]};
         5: return {1'b0, pb[7:6]};
         6: return pb[10:8];
         default: return {1'b0, pb[12:11]};
      endcase
   endfunction
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic cmp_pins(input logic [39:0] got, input logic [39:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Single transfer, address phase then data phase; the next call starts only after this data phase has ended.
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic check_pins();
      logic [7:0] eo;
      logic [7:0] ee;
      logic [7:0][4:0] ef;
      logic [2:0] c;
      ef = '0;
      for (int p = 0; p < 8; p++) begin
         c = code_of(p);
         if (md[p] && c <= (p == 0 ? 3'h1 : p == 6 ? 3'h4 : 3'h2)) begin
            eo[p] = func_out[p][c];
            ee[p] = func_oe[p][c];
            ef[p][c] = pad_in[p];
         end else begin
            eo[p] = gpio_out[p];
            ee[p] = gpio_oe[p];
         end
      end
      cmp_pins({32'h0, pad_out}, {32'h0, eo}, "pad_out");
      cmp_pins({32'h0, pad_oe}, {32'h0, ee}, "pad_oe");
      cmp_pins(func_in, ef, "func_in");
   endtask
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge hclk);
      fail_count++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int k = 0; k < 3; k++) begin
         bus(8'h14 + 8'h04 * k[7:0], 1'b0, 32'h0);
         cmp_word(rd, 32'h0, "reset value");
      end
      for (int i = 0; i < 48; i++) begin
         r = rnd();
         pa = (i < 8) ? {2'h3, i[1:0], i[1:0], i[1:0], 1'b1, i[0], 6'h3f} : r[15:0];
         pb = (i < 8) ? {3'h7, i[1:0], i[2:0], i[1:0], i[1:0], 4'hf} : r[31:16];
         r = rnd();
         md = (i < 8) ? 8'hff : r[7:0];
         // Port A bits 15-14 and 7, port B bit 3 and the reserved port B pin 4 codes are never written.
         pa = pa & 16'h3f7f;
         pb = pb & 16'hfff7;
         if (pb[10]) pb[9:8] = 2'h0;
         bus(8'h14, 1'b1, {r[31:16], pa});
         bus(8'h18, 1'b1, {16'h0, pb});
         bus(8'h1c, 1'b1, {24'h0, md});
         bus(8'h24, 1'b1, 32'hffffffff);
         r = rnd();
         gpio_out <= r[7:0];
         gpio_oe <= r[15:8];
         pad_in <= r[23:16];
         w = {rnd(), rnd()};
         func_out <= w[39:0];
         w = {rnd(), rnd()};
         func_oe <= w[39:0];
         bus(8'h14, 1'b0, 32'h0);
         cmp_word(rd, {16'h0, pa & pin_select_pkg::porta_sel_mask}, "port a");
         bus(8'h18, 1'b0, 32'h0);
         cmp_word(rd, {16'h0, pb & pin_select_pkg::portb_sel_mask}, "port b");
         bus(8'h24, 1'b0, 32'h0);
         cmp_word(rd, 32'h0, "unmapped");
         bus(8'h1c, 1'b0, 32'h0);
         cmp_word(rd, {24'h0, md}, "mode readback");
         bus(8'h20, 1'b0, 32'h0);
         cmp_word(rd, {24'h0, pad_in}, "pin level");
         check_pins();
      end
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(8'h1c, 1'b0, 32'h0);
      cmp_word(rd, 32'h0, "mode after reset");
      pa = 16'h0;
      pb = 16'h0;
      md = 8'h0;
      @(posedge hclk);
      check_pins();
      end_sim();
   end
endmodule
`default_nettype wire
